// [pkg/dbglk_pkg.sv]
// Shared constants and state types of the single-wire debug link
package dbglk_pkg;

    localparam int CNT_W = 12;

    // Bit cell positions, in serial clocks from the cell's falling edge
    localparam logic [3:0] BIT_LOW_END = 4'h4;
    localparam logic [3:0] BIT_ZERO_END = 4'hd;
    localparam logic [3:0] BIT_SAMPLE = 4'ha;
    localparam logic [3:0] BIT_LAST = 4'hf;
    localparam logic [2:0] CMD_LAST_BIT = 3'h7;

    // Command byte fields
    localparam int CMD_STATUS_POS = 7;
    localparam int CMD_ACCESS_POS = 6;

    // Timing counts in serial clocks (one serial clock per core_clk)
    localparam logic [CNT_W-1:0] ACK_DLY_EN = 12'h020;
    localparam logic [CNT_W-1:0] RSP_DLY_DIS = 12'h010;
    localparam logic [CNT_W-1:0] ACK_NORMAL = 12'h010;
    localparam logic [CNT_W-1:0] ACK_LONG = 12'h040;
    localparam logic [CNT_W-1:0] LONG_THRESH = 12'h030;
    localparam logic [CNT_W-1:0] STATUS_WAIT = 12'h200;
    localparam logic [CNT_W-1:0] SYNC_MIN = 12'h080;
    localparam logic [CNT_W-1:0] SYNC_HOST = 12'h088;
    localparam logic [CNT_W-1:0] SYNC_RSP = 12'h080;
    localparam logic [CNT_W-1:0] SYNC_RSP_DLY = 12'h010;
    localparam logic [CNT_W-1:0] HOST_ACK_TMO = 12'h800;
    // Access grant timeout in core clocks
    localparam logic [CNT_W-1:0] ACC_TIMEOUT = 12'h200;

    typedef enum logic [6:0] {
        D_RX   = 7'h01,
        D_WAIT = 7'h02,
        D_ACK  = 7'h04,
        D_SPD  = 7'h08,
        D_SYNW = 7'h10,
        D_SYNL = 7'h20,
        D_SYNS = 7'h40
    } dbglk_dstate_type;

    typedef enum logic [8:0] {
        H_IDLE = 9'h001,
        H_TX   = 9'h002,
        H_RDLY = 9'h004,
        H_STW  = 9'h008,
        H_ACKW = 9'h010,
        H_ACKL = 9'h020,
        H_ABL  = 9'h040,
        H_ABS  = 9'h080,
        H_SYL  = 9'h100
    } dbglk_hstate_type;

endpackage

// [pkg/dbglk_if.sv]
// Single-wire debug link between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface dbglk_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic wire_level;

    // Open-drain wire with pull-up: low when either end drives low
    assign wire_level = !((dev_oe && !dev_out) || (host_oe && !host_out));

    modport device (
        input wire_level,
        output dev_out,
        output dev_oe
    );

    modport host (
        input wire_level,
        output host_out,
        output host_oe
    );
endinterface
`default_nettype wire

// [core/dbglk_device.sv]
// Device end: command receive, acknowledge timing and abort by sync
//
// Summary of operation
// - Only one command awaits acknowledge at once
// - Host aborts unacknowledged command before new one
// - Host may abort pending acknowledge any time
// - With-status commands never produce an acknowledge
// - Host waits 512 cycles for with-status data
// - Error gives 64-clock low pulse plus speedup
// - Host may read status after long acknowledge
// - Acknowledge starts at least 32 clocks after end
// - Command ends at 16th clock of last bit
// - Acknowledge disabled: response delay is 16 clocks
// - Access not granted in 512 clocks: abort, flag
// - First acknowledge after low-power entry is long while link_enable is set
// - Abort: host holds low 128+, then speedup
// - Long low pulse: sync response, drop command
// - Host sends only after sync completes, or after a 2048-clock sync timeout while no_ack is clear
// - Host abort pulse slightly longer than 128
`timescale 1ns/1ps
`default_nettype none
module dbglk_device
    import dbglk_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    dbglk_if.device link,
    input wire logic ack_enable,
    input wire logic link_enable,
    input wire logic low_power_entry,
    input wire logic cmd_error,
    input wire logic access_grant,
    input wire logic no_response_clear,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic access_req,
    output logic no_response_flag,
    output logic busy
);

    dbglk_dstate_type state_reg;
    dbglk_dstate_type state_next;
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic cell_act_reg;
    logic [3:0] cell_cnt_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [CNT_W-1:0] pulse_cnt_reg;
    logic [CNT_W-1:0] pulse_len_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic sync_seen_reg;
    logic long_reg;
    logic exc_reg;
    logic status_cmd_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic fall;
    logic rise;
    logic cmd_end;
    logic dly_done;
    logic acc_tmo;
    logic sync_go;
    logic ack_go;
    logic want_long;
    logic [CNT_W-1:0] dly_need;

    assign link.dev_out = pin_out_reg;
    assign link.dev_oe = pin_oe_reg;

    // Pin synchroniser; edges come from the second stage onward
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= link.wire_level;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign fall = prev_reg && !sync2_reg;
    assign rise = !prev_reg && sync2_reg;
    // A cell still low at its end is no bit, so a sync pulse never
    // completes a command
    assign cmd_end = (state_reg == D_RX) && cell_act_reg &&
        (cell_cnt_reg == BIT_LAST) && sync2_reg &&
        (bit_cnt_reg == CMD_LAST_BIT);
    assign dly_need = ack_enable ? ACK_DLY_EN : RSP_DLY_DIS;
    assign dly_done = pulse_cnt_reg >= (dly_need - 12'h001);
    assign acc_tmo = (state_reg == D_WAIT) && access_req &&
        !access_grant &&
        (pulse_cnt_reg == (ACC_TIMEOUT - 12'h001));
    assign sync_go = sync_seen_reg && rise;
    assign ack_go = (state_reg == D_WAIT) && (state_next == D_ACK);
    assign want_long = long_reg || cmd_error ||
        (link_enable && exc_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            D_RX: begin
                if (cmd_end) begin
                    state_next = D_WAIT;
                end
            end
            D_WAIT: begin
                if (dly_done && !access_req) begin
                    if (ack_enable && !status_cmd_reg) begin
                        state_next = D_ACK;
                    end else begin
                        state_next = D_RX;
                    end
                end
            end
            D_ACK: begin
                if (pulse_cnt_reg == (pulse_len_reg - 12'h001)) begin
                    state_next = D_SPD;
                end
            end
            D_SPD: begin
                state_next = D_RX;
            end
            D_SYNW: begin
                if (pulse_cnt_reg == (SYNC_RSP_DLY - 12'h001)) begin
                    state_next = D_SYNL;
                end
            end
            D_SYNL: begin
                if (pulse_cnt_reg == (SYNC_RSP - 12'h001)) begin
                    state_next = D_SYNS;
                end
            end
            D_SYNS: begin
                state_next = D_RX;
            end
            default: begin
                state_next = D_RX;
            end
        endcase
        if (sync_go) begin
            state_next = D_SYNW;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= D_RX;
            pulse_cnt_reg <= 12'h000;
            pulse_len_reg <= ACK_NORMAL;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                pulse_cnt_reg <= 12'h000;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg + 12'h001;
            end
            if (ack_go) begin
                pulse_len_reg <= want_long ? ACK_LONG : ACK_NORMAL;
            end
        end
    end

    // New bits are taken only in D_RX, so acknowledges cannot nest
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cell_act_reg <= 1'b0;
            cell_cnt_reg <= 4'h0;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (sync_go || state_reg != D_RX) begin
            cell_act_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
        end else if (cell_act_reg) begin
            cell_cnt_reg <= cell_cnt_reg + 4'h1;
            if (cell_cnt_reg == BIT_SAMPLE) begin
                shift_reg <= {shift_reg[6:0], sync2_reg};
            end
            if (cell_cnt_reg == BIT_LAST) begin
                cell_act_reg <= 1'b0;
                bit_cnt_reg <= sync2_reg ? bit_cnt_reg + 3'h1 : 3'h0;
            end
        end else if (fall) begin
            // Fall cycle is position 0, so the next fall is not missed
            cell_act_reg <= 1'b1;
            cell_cnt_reg <= 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_valid <= 1'b0;
            cmd_byte <= 8'h00;
            status_cmd_reg <= 1'b0;
            access_req <= 1'b0;
        end else begin
            cmd_valid <= cmd_end;
            if (cmd_end) begin
                cmd_byte <= shift_reg;
                status_cmd_reg <= shift_reg[CMD_STATUS_POS];
            end
            if (sync_go || acc_tmo || access_grant) begin
                access_req <= 1'b0;
            end else if (cmd_end) begin
                access_req <= shift_reg[CMD_ACCESS_POS];
            end
        end
    end

    // Error flags; a set in the clearing cycle wins, except for long_reg, where the clear wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            long_reg <= 1'b0;
            exc_reg <= 1'b0;
            no_response_flag <= 1'b0;
        end else begin
            if (sync_go || cmd_end) begin
                long_reg <= 1'b0;
            end else if (state_reg == D_WAIT && (cmd_error || acc_tmo)) begin
                long_reg <= 1'b1;
            end
            exc_reg <= (exc_reg && !ack_go) ||
                (low_power_entry && link_enable);
            no_response_flag <= (no_response_flag && !no_response_clear) ||
                acc_tmo;
        end
    end

    // Long low detection ignores our own drive
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= 12'h000;
            sync_seen_reg <= 1'b0;
        end else begin
            if (sync2_reg || pin_oe_reg) begin
                low_cnt_reg <= 12'h000;
            end else if (low_cnt_reg != SYNC_MIN) begin
                low_cnt_reg <= low_cnt_reg + 12'h001;
            end
            if (rise) begin
                sync_seen_reg <= 1'b0;
            end else if (low_cnt_reg == (SYNC_MIN - 12'h001)) begin
                sync_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_oe_reg <= 1'b0;
            pin_out_reg <= 1'b1;
            busy <= 1'b0;
        end else begin
            pin_oe_reg <= (state_next == D_ACK) || (state_next == D_SPD) ||
                (state_next == D_SYNL) || (state_next == D_SYNS);
            pin_out_reg <= (state_next == D_SPD) ||
                (state_next == D_SYNS);
            busy <= state_next != D_RX;
        end
    end

endmodule
`default_nettype wire

// [core/dbglk_host.sv]
// Host end: command transmit, acknowledge wait and sync abort
`timescale 1ns/1ps
`default_nettype none
module dbglk_host
    import dbglk_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    dbglk_if.host link,
    input wire logic send_valid,
    input wire logic [7:0] send_byte,
    input wire logic ack_enable,
    input wire logic abort_req,
    output logic send_ready,
    output logic ack_seen,
    output logic long_ack,
    output logic cmd_done,
    output logic no_ack,
    output logic sync_done
);

    dbglk_hstate_type state_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] bit_idx_reg;
    logic [7:0] tx_reg;
    logic status_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic fall;
    logic rise;
    logic [3:0] pos_next;

    assign link.host_out = pin_out_reg;
    assign link.host_oe = pin_oe_reg;

    function automatic logic cell_level(input logic [3:0] pos,
                                        input logic b);
        cell_level = (pos < BIT_LOW_END) ? 1'b0 :
            ((pos < BIT_ZERO_END) ? b : 1'b1);
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= link.wire_level;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign fall = prev_reg && !sync2_reg;
    assign rise = !prev_reg && sync2_reg;
    assign pos_next = cnt_reg[3:0] + 4'h1;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            send_ready <= 1'b0;
        end else begin
            // Abort beats a send offered in the same cycle
            send_ready <= (state_reg == H_IDLE) && !no_ack && !abort_req &&
                !(send_ready && send_valid);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= H_IDLE;
            cnt_reg <= 12'h000;
            bit_idx_reg <= 3'h0;
            tx_reg <= 8'h00;
            status_reg <= 1'b0;
            pin_out_reg <= 1'b1;
            pin_oe_reg <= 1'b0;
            ack_seen <= 1'b0;
            long_ack <= 1'b0;
            cmd_done <= 1'b0;
            no_ack <= 1'b0;
            sync_done <= 1'b0;
        end else begin
            ack_seen <= 1'b0;
            long_ack <= 1'b0;
            cmd_done <= 1'b0;
            sync_done <= 1'b0;
            cnt_reg <= cnt_reg + 12'h001;
            case (state_reg)
                H_IDLE: begin
                    if (abort_req) begin
                        state_reg <= H_ABL;
                        cnt_reg <= 12'h000;
                        pin_oe_reg <= 1'b1;
                        pin_out_reg <= 1'b0;
                    end else if (send_ready && send_valid) begin
                        state_reg <= H_TX;
                        tx_reg <= send_byte;
                        status_reg <= send_byte[CMD_STATUS_POS];
                        bit_idx_reg <= 3'h0;
                        cnt_reg <= 12'h000;
                        pin_oe_reg <= 1'b1;
                        pin_out_reg <= 1'b0;
                    end
                end
                H_TX: begin
                    if (cnt_reg[3:0] == BIT_LAST) begin
                        cnt_reg <= 12'h000;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        if (bit_idx_reg == CMD_LAST_BIT) begin
                            pin_oe_reg <= 1'b0;
                            pin_out_reg <= 1'b1;
                            if (!ack_enable) begin
                                state_reg <= H_RDLY;
                            end else if (status_reg) begin
                                state_reg <= H_STW;
                            end else begin
                                state_reg <= H_ACKW;
                            end
                        end else begin
                            bit_idx_reg <= bit_idx_reg + 3'h1;
                            pin_out_reg <= 1'b0;
                        end
                    end else begin
                        pin_out_reg <= cell_level(pos_next, tx_reg[7]);
                    end
                end
                H_RDLY: begin
                    if (cnt_reg == (RSP_DLY_DIS - 12'h001)) begin
                        cmd_done <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                H_STW: begin
                    if (cnt_reg == (STATUS_WAIT - 12'h001)) begin
                        cmd_done <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                H_ACKW: begin
                    if (abort_req) begin
                        state_reg <= H_ABL;
                        cnt_reg <= 12'h000;
                        pin_oe_reg <= 1'b1;
                        pin_out_reg <= 1'b0;
                    end else if (fall) begin
                        state_reg <= H_ACKL;
                        cnt_reg <= 12'h000;
                    end else if (cnt_reg == (HOST_ACK_TMO - 12'h001)) begin
                        no_ack <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                H_ACKL: begin
                    if (rise) begin
                        ack_seen <= 1'b1;
                        long_ack <= cnt_reg >= LONG_THRESH;
                        state_reg <= H_IDLE;
                    end
                end
                H_ABL: begin
                    // Margin above the minimum keeps it clear of the limit
                    if (cnt_reg == (SYNC_HOST - 12'h001)) begin
                        pin_out_reg <= 1'b1;
                        state_reg <= H_ABS;
                    end
                end
                H_ABS: begin
                    pin_oe_reg <= 1'b0;
                    cnt_reg <= 12'h000;
                    state_reg <= H_SYL;
                end
                H_SYL: begin
                    // Wait for the device's sync response to end; the
                    // rise of our own speedup comes well before that
                    if (rise && cnt_reg > SYNC_RSP_DLY) begin
                        sync_done <= 1'b1;
                        no_ack <= 1'b0;
                        state_reg <= H_IDLE;
                    end else if (cnt_reg == (HOST_ACK_TMO - 12'h001)) begin
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [tb/dbglk_monitor.sv]
// Wire-level handshake checks for the debug link
`timescale 1ns/1ps
`default_nettype none
module dbglk_monitor (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic wire_level
);
    logic dev_low;
    logic host_low;
    logic [11:0] dl_cnt_reg;
    logic [11:0] hl_cnt_reg;
    logic [11:0] gap_reg;
    logic [1:0] ack_cnt_reg;
    logic abort_reg;

    assign dev_low = dev_oe && !dev_out;
    assign host_low = host_oe && !host_out;

    // Pulse lengths, read back on the cycle the pulse ends
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dl_cnt_reg <= 12'h000;
            hl_cnt_reg <= 12'h000;
        end else begin
            dl_cnt_reg <= dev_low ? dl_cnt_reg + 12'h001 : 12'h000;
            hl_cnt_reg <= host_low ? hl_cnt_reg + 12'h001 : 12'h000;
        end
    end

    // Quiet time since host release, saturating
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 12'h000;
        end else if (host_oe) begin
            gap_reg <= 12'h000;
        end else if (gap_reg != 12'hfff) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    // Acks per host transfer; an abort opens a fresh transfer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_cnt_reg <= 2'h0;
        end else if (host_oe) begin
            ack_cnt_reg <= 2'h0;
        end else if (dev_low && dl_cnt_reg == 12'h000) begin
            ack_cnt_reg <= (ack_cnt_reg == 2'h3) ? 2'h3 : ack_cnt_reg + 2'h1;
        end
    end

    // Last host low pulse was an abort request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            abort_reg <= 1'b0;
        end else if (!host_low && hl_cnt_reg != 12'h000) begin
            abort_reg <= hl_cnt_reg >= 12'h080;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence dev_speedup;
        dev_oe && dev_out ##1 !dev_oe;
    endsequence

    sequence sync_reply;
        ##[1:40] dev_low;
    endsequence

    a_ack_length: assert property ($fell(dev_low) && !abort_reg
        |-> dl_cnt_reg == 12'h010 || dl_cnt_reg == 12'h040)
        else $error("ack pulse length off");
    a_ack_speedup: assert property ($fell(dev_low) |-> dev_speedup)
        else $error("no speedup after device pulse");
    a_ack_delay: assert property ($rose(dev_low) && !abort_reg
        |-> gap_reg >= 12'h020)
        else $error("ack started too early");
    a_single_ack: assert property ($rose(dev_low) |-> ack_cnt_reg == 2'h0)
        else $error("second ack for one command");
    a_sync_reply: assert property ($fell(host_oe) && abort_reg
        |-> sync_reply)
        else $error("no sync reply after abort");
    a_sync_length: assert property ($fell(dev_low) && abort_reg
        |-> dl_cnt_reg == 12'h080)
        else $error("sync reply length off");
    a_abort_margin: assert property ($fell(host_low)
        && hl_cnt_reg > 12'h010 |-> hl_cnt_reg > 12'h080)
        else $error("abort pulse too short");
    a_host_speedup: assert property ($fell(host_low)
        && hl_cnt_reg > 12'h010 |-> host_oe && host_out ##1 !host_oe)
        else $error("no speedup after abort");
    a_bit_cell: assert property ($fell(host_low) && hl_cnt_reg <= 12'h010
        |-> hl_cnt_reg == 12'h004 || hl_cnt_reg == 12'h00d)
        else $error("bit cell low time off");
    a_wire_idle: assert property (!dev_oe && !host_oe |-> wire_level)
        else $error("released wire not high");
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench joining host end and device end
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value at %0t: %s", $time, msg); \
        end \
    end
module tb;
    localparam logic [3:0] ACK_N = 4'h8;
    localparam logic [3:0] ACK_L = 4'hc;
    localparam logic [3:0] DONE = 4'h2;
    localparam logic [3:0] SYNC = 4'h1;
    localparam logic [3:0] NOACK = 4'hf;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic dev_ack_en = 1'b1, host_ack_en = 1'b1, link_enable = 1'b1;
    logic low_power_entry = 1'b0, cmd_error = 1'b0, access_grant = 1'b0;
    logic no_response_clear = 1'b0, send_valid = 1'b0, abort_req = 1'b0;
    logic [7:0] send_byte = 8'h00;
    logic cmd_valid, access_req, no_response_flag, busy, send_ready;
    logic ack_seen, long_ack, cmd_done, no_ack, sync_done;
    logic [7:0] cmd_byte;
    logic grant_on = 1'b0, no_ack_q = 1'b0;
    logic [3:0] obs;
    logic [7:0] b;
    logic [3:0] exp_host[$];
    logic [7:0] exp_dev[$];
    int failures = 0, n_compared = 0;

    dbglk_if link_if ();
    dbglk_device i_dbglk_device (.core_clk(core_clk), .rstn(rstn),
        .link(link_if), .ack_enable(dev_ack_en), .link_enable(link_enable),
        .low_power_entry(low_power_entry), .cmd_error(cmd_error),
        .access_grant(access_grant), .no_response_clear(no_response_clear),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .access_req(access_req),
        .no_response_flag(no_response_flag), .busy(busy));
    dbglk_host i_dbglk_host (.core_clk(core_clk), .rstn(rstn),
        .link(link_if), .send_valid(send_valid), .send_byte(send_byte),
        .ack_enable(host_ack_en), .abort_req(abort_req),
        .send_ready(send_ready), .ack_seen(ack_seen), .long_ack(long_ack),
        .cmd_done(cmd_done), .no_ack(no_ack), .sync_done(sync_done));
    dbglk_monitor i_dbglk_monitor (.core_clk(core_clk), .rstn(rstn),
        .dev_out(link_if.dev_out), .dev_oe(link_if.dev_oe),
        .host_out(link_if.host_out), .host_oe(link_if.host_oe),
        .wire_level(link_if.wire_level));

    always #5 core_clk = ~core_clk;

    // Grant answers one cycle after the request while enabled
    always @(posedge core_clk) begin
        access_grant <= grant_on && access_req === 1'b1 && !access_grant;
    end

    // Result watcher: every host event or command takes the oldest note
    always @(posedge core_clk) begin
        if (rstn === 1'b1) begin
            obs = {ack_seen, long_ack, cmd_done, sync_done};
            if (no_ack === 1'b1 && no_ack_q !== 1'b1) begin
                obs = NOACK;
            end
            no_ack_q = no_ack;
            if (obs !== 4'h0) begin
                `CHK(obs, exp_host.size() ? exp_host.pop_front() : 4'hx,
                    "host result")
            end
            if (cmd_valid !== 1'b0) begin
                `CHK(cmd_byte, exp_dev.size() ? exp_dev.pop_front() : 8'hxx,
                    "command byte")
            end
        end
    end

    task automatic results();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] v, input logic [3:0] code);
        int n;
        n = 0;
        exp_dev.push_back(v);
        if (code != 4'h0) exp_host.push_back(code);
        send_byte <= v;
        send_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (send_ready !== 1'b1 && n < 300);
        send_valid <= 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((exp_host.size() + exp_dev.size()) != 0 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 4000) begin
            failures++;
            $display("wrong value at %0t: no result", $time);
        end
        repeat (8) @(posedge core_clk);
    endtask

    task automatic abort_link();
        exp_host.push_back(SYNC);
        abort_req <= 1'b1;
        @(posedge core_clk);
        abort_req <= 1'b0;
        drain();
    endtask

    initial begin
        void'($urandom(32'h935bfc45));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom());
            send({2'b00, b[5:0]}, ACK_N);
            drain();
        end
        cmd_error <= 1'b1;
        send({2'b00, b[5:0]}, ACK_L);
        drain();
        cmd_error <= 1'b0;
        b = 8'($urandom());
        send({2'b10, b[5:0]}, DONE);
        drain();
        dev_ack_en <= 1'b0;
        host_ack_en <= 1'b0;
        send({2'b00, b[5:0]}, DONE);
        drain();
        dev_ack_en <= 1'b1;
        host_ack_en <= 1'b1;
        grant_on <= 1'b1;
        send({2'b01, b[5:0]}, ACK_N);
        drain();
        grant_on <= 1'b0;
        send({2'b01, b[5:0]}, ACK_L);
        drain();
        `CHK(no_response_flag, 1'b1, "flag after timeout")
        `CHK(access_req, 1'b0, "request after timeout")
        no_response_clear <= 1'b1;
        @(posedge core_clk);
        no_response_clear <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(no_response_flag, 1'b0, "flag after clear")
        for (int le = 0; le < 2; le++) begin
            link_enable <= le[0];
            low_power_entry <= 1'b1;
            @(posedge core_clk);
            low_power_entry <= 1'b0;
            send(8'h15, le ? ACK_L : ACK_N);
            drain();
            link_enable <= 1'b1;
        end
        send(8'h2a, ACK_N);
        drain();
        // Abort while the access waits, well before its own timeout
        send({2'b01, b[5:0]}, 4'h0);
        for (int n = 0; n < 400 && access_req !== 1'b1; n++) begin
            @(posedge core_clk);
        end
        repeat (50) @(posedge core_clk);
        `CHK(busy, 1'b1, "busy while waiting")
        abort_link();
        `CHK(no_response_flag, 1'b0, "flag after abort")
        `CHK(access_req, 1'b0, "request after abort")
        send(8'h3c, ACK_N);
        drain();
        // Device silent, host times out and must abort
        dev_ack_en <= 1'b0;
        send(8'h0f, NOACK);
        drain();
        dev_ack_en <= 1'b1;
        abort_link();
        send(8'h33, ACK_N);
        drain();
        results();
    end

    // Tests take about 6500 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        results();
    end
endmodule
`default_nettype wire
